// [lpdb_regs.vh]
// Constants for the DRAM power-state and bank-state sequencer
// Operation
// - Stay in active power down while enable low
// - Enable rise with deselect exits to active
// - Idle power down holds, exits to idle
// - Self refresh enable fall stops command decoding
// - Self refresh enable rise restores command decoding
// - Banks active plus enable fall: active power down
// - All banks idle plus enable fall: idle power down
// - Clock enable is asynchronous, synchronised separately
// - Self refresh accepts mode register, multipurpose and exit only
// - Idle power down: outputs float or terminate
// - Bank table only when enabled and exited
// - Activate starts activating; refresh starts bank refresh
// - Active bank takes reads and writes
// - Write after read waits burst end
// - Read after write waits burst end
// - Precharging: no-op or mode register read; auto precharge: no-op only
// - Refreshing or mode access: no-op only
// - Refreshes end idle after their periods
// - Mode access returns to idle, or to active from an open bank
`ifndef LPDB_REGS_VH
`define LPDB_REGS_VH

// Decoded command codes on cmd_code_i
`define LPDB_CMD_ACT   4'h1
`define LPDB_CMD_RD    4'h2
`define LPDB_CMD_WR    4'h3
`define LPDB_CMD_PRE   4'h4
`define LPDB_CMD_REFPB 4'h5
`define LPDB_CMD_REFAB 4'h6
`define LPDB_CMD_MRR   4'h7
`define LPDB_CMD_MRW   4'h8
`define LPDB_CMD_MPC   4'h9
`define LPDB_CMD_SRE   4'ha
`define LPDB_CMD_SRX   4'hb

// Device power states
`define LPDB_PWR_NORM  3'h0
`define LPDB_PWR_APD   3'h1
`define LPDB_PWR_IPD   3'h2
`define LPDB_PWR_SR    3'h3
`define LPDB_PWR_SRPD  3'h4
`define LPDB_PWR_EXIT  3'h5

// Bank states
`define LPDB_BK_IDLE   4'h0
`define LPDB_BK_ACTG   4'h1
`define LPDB_BK_ACTV   4'h2
`define LPDB_BK_RD     4'h3
`define LPDB_BK_WR     4'h4
`define LPDB_BK_RDAP   4'h5
`define LPDB_BK_WRAP   4'h6
`define LPDB_BK_PRE    4'h7
`define LPDB_BK_REFPB  4'h8
`define LPDB_BK_REFAB  4'h9
`define LPDB_BK_MRR    4'ha
`define LPDB_BK_MRW    4'hb

// Default residence periods in clock cycles, and the link clock edge count needed for an exit
`define LPDB_XP_CYC    8
`define LPDB_XSR_CYC   32
`define LPDB_RP_CYC    4
`define LPDB_RCD_CYC   4
`define LPDB_RFCPB_CYC 24
`define LPDB_RFCAB_CYC 48
`define LPDB_MRR_CYC   8
`define LPDB_MRW_CYC   10
`define LPDB_BURST_CYC 8
`define LPDB_CK_EDGES  2'h2

`endif

// [lpdb_sync.v]
// Three-stage synchroniser with agreement filter and edge pulses
`timescale 1ns/100ps
module lpdb_sync (
  input  wire sys_clk_i,
  input  wire rst_n_i,
  input  wire async_i,
  output reg  level_o,
  output reg  rise_o,
  output reg  fall_o
);

  reg s1_reg; // Metastable stage, read only by s2
  reg s2_reg;
  reg s3_reg;

  // Shift chain; the level moves only when stages two and three agree
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
      s3_reg  <= 1'b0;
      level_o <= 1'b0;
      rise_o  <= 1'b0;
      fall_o  <= 1'b0;
    end else begin
      s1_reg  <= async_i;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      rise_o  <= 1'b0;
      fall_o  <= 1'b0;
      if (s2_reg == s3_reg && s3_reg != level_o) begin
        level_o <= s3_reg;
        rise_o  <= s3_reg;
        fall_o  <= ~s3_reg;
      end
    end
  end

endmodule

// [lpdb_core.v]
// Power-state and per-bank state sequencer of a low-power DRAM channel
`timescale 1ns/100ps
`include "lpdb_regs.vh"
module lpdb_core #(
  parameter NUM_BANKS = 8,
  parameter XP_CYC    = `LPDB_XP_CYC,
  parameter XSR_CYC   = `LPDB_XSR_CYC,
  parameter RP_CYC    = `LPDB_RP_CYC,
  parameter RCD_CYC   = `LPDB_RCD_CYC,
  parameter RFCPB_CYC = `LPDB_RFCPB_CYC,
  parameter RFCAB_CYC = `LPDB_RFCAB_CYC,
  parameter MRR_CYC   = `LPDB_MRR_CYC,
  parameter MRW_CYC   = `LPDB_MRW_CYC,
  parameter BURST_CYC = `LPDB_BURST_CYC
) (
  input  wire                   sys_clk_i,
  input  wire                   rst_n_i,
  input  wire                   cke_i,
  input  wire                   ck_i,
  input  wire                   cmd_valid_i,
  input  wire [3:0]             cmd_code_i,
  input  wire [2:0]             cmd_bank_i,
  input  wire                   cmd_all_bank_i,
  input  wire                   auto_precharge_flag_i,
  input  wire                   on_die_termination_i,
  output reg  [2:0]             power_state_o,
  output reg  [NUM_BANKS*4-1:0] bank_state_o,
  output reg                    cmd_decode_en_o,
  output reg                    exit_ready_o,
  output reg                    dq_hiz_o,
  output reg                    dq_term_o,
  output reg                    illegal_cmd_o
);

  // Synchronised clock enable and sampled link clock
  wire cke_lvl;     // Filtered clock enable level
  wire cke_rise;    // One-cycle pulse on low-to-high
  wire cke_fall;    // One-cycle pulse on high-to-low
  wire ck_rise;     // Link clock rising edge seen

  // Power state machine registers
  reg  [2:0] pwr_reg;
  reg  [2:0] pwr_next;
  reg  [7:0] exit_tmr_reg;   // Exit period countdown
  reg  [7:0] exit_tmr_next;
  reg  [1:0] ck_cnt_reg;     // Link clock edges seen during exit
  reg  [1:0] ck_cnt_next;
  reg  [2:0] exit_to_reg;    // State entered once exit completes
  reg  [2:0] exit_to_next;

  // Bank summaries
  wire [NUM_BANKS-1:0] bank_idle;
  wire [NUM_BANKS-1:0] bank_err;
  wire                 all_idle;
  wire                 dec_en;   // Bank table is in force
  wire                 sr_dec;   // Self refresh command decoding live
  wire                 sr_bad;   // Command refused in self refresh

  // Decides whether a command names a given bank
  function hits;
    input [3:0] code;
    input [2:0] bank;
    input       all;
    input [2:0] idx;
    begin
      case (code)
        `LPDB_CMD_REFAB, `LPDB_CMD_MRR, `LPDB_CMD_MRW: hits = 1'b1;
        `LPDB_CMD_PRE: hits = all | (bank == idx);
        `LPDB_CMD_MPC, `LPDB_CMD_SRE, `LPDB_CMD_SRX: hits = 1'b0;
        default: hits = (bank == idx);
      endcase
    end
  endfunction

  // Clock enable has no relation to the command clock, so it is filtered
  lpdb_sync u_cke_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (cke_i),
    .level_o   (cke_lvl),
    .rise_o    (cke_rise),
    .fall_o    (cke_fall)
  );

  // Link clock sampled only to count rising edges during an exit
  lpdb_sync u_ck_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (ck_i),
    .level_o   (),
    .rise_o    (ck_rise),
    .fall_o    ()
  );

  assign all_idle = &bank_idle;

  // Bank table only with enable high on both samples and outside any exit
  assign dec_en = (pwr_reg == `LPDB_PWR_NORM) & cke_lvl & ~cke_fall & ~cke_rise;

  // Self refresh decodes only while enable stays high
  assign sr_dec = (pwr_reg == `LPDB_PWR_SR) & cke_lvl & ~cke_fall;

  // Only mode register, multipurpose and exit are accepted in self refresh
  assign sr_bad = sr_dec & cmd_valid_i & (cmd_code_i != `LPDB_CMD_MRR) & (cmd_code_i != `LPDB_CMD_MRW)
                  & (cmd_code_i != `LPDB_CMD_MPC) & (cmd_code_i != `LPDB_CMD_SRX);

  // Power state next-value logic
  always @* begin
    pwr_next      = pwr_reg;
    exit_tmr_next = exit_tmr_reg;
    ck_cnt_next   = ck_cnt_reg;
    exit_to_next  = exit_to_reg;
    case (pwr_reg)
      `LPDB_PWR_NORM: begin
        // Enable toggles are only honoured with deselect on the bus
        if (cke_fall && !cmd_valid_i) begin
          if (all_idle)
            pwr_next = `LPDB_PWR_IPD;
          else
            pwr_next = `LPDB_PWR_APD;
        end else if (dec_en && cmd_valid_i && cmd_code_i == `LPDB_CMD_SRE && all_idle) begin
          pwr_next = `LPDB_PWR_SR;
        end
      end
      `LPDB_PWR_APD: begin
        // Bus is ignored while enable stays low
        if (cke_rise && !cmd_valid_i) begin
          pwr_next      = `LPDB_PWR_EXIT;
          exit_tmr_next = XP_CYC[7:0];
          ck_cnt_next   = 2'h0;
          exit_to_next  = `LPDB_PWR_NORM;
        end
      end
      `LPDB_PWR_IPD: begin
        if (cke_rise && !cmd_valid_i) begin
          pwr_next      = `LPDB_PWR_EXIT;
          exit_tmr_next = XP_CYC[7:0];
          ck_cnt_next   = 2'h0;
          exit_to_next  = `LPDB_PWR_NORM;
        end
      end
      `LPDB_PWR_SR: begin
        if (cke_fall && !cmd_valid_i) begin
          pwr_next = `LPDB_PWR_SRPD;
        end else if (sr_dec && cmd_valid_i && cmd_code_i == `LPDB_CMD_SRX) begin
          pwr_next      = `LPDB_PWR_EXIT;
          exit_tmr_next = XSR_CYC[7:0];
          ck_cnt_next   = 2'h0;
          exit_to_next  = `LPDB_PWR_NORM;
        end
      end
      `LPDB_PWR_SRPD: begin
        // Decoding returns but the device stays in self refresh
        if (cke_rise && !cmd_valid_i)
          pwr_next = `LPDB_PWR_SR;
      end
      `LPDB_PWR_EXIT: begin
        // Exit period counts regardless of the bus
        if (ck_rise && ck_cnt_reg != `LPDB_CK_EDGES)
          ck_cnt_next = ck_cnt_reg + 2'h1;
        if (exit_tmr_reg > 8'h1)
          exit_tmr_next = exit_tmr_reg - 8'h1;
        else
          pwr_next = exit_to_reg;
      end
      default: pwr_next = `LPDB_PWR_NORM;
    endcase
  end

  // Power state registers and registered outputs
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwr_reg         <= `LPDB_PWR_NORM;
      exit_tmr_reg    <= 8'h00;
      ck_cnt_reg      <= 2'h0;
      exit_to_reg     <= `LPDB_PWR_NORM;
      power_state_o   <= `LPDB_PWR_NORM;
      cmd_decode_en_o <= 1'b0;
      exit_ready_o    <= 1'b0;
      dq_hiz_o        <= 1'b0;
      dq_term_o       <= 1'b0;
      illegal_cmd_o   <= 1'b0;
    end else begin
      pwr_reg         <= pwr_next;
      exit_tmr_reg    <= exit_tmr_next;
      ck_cnt_reg      <= ck_cnt_next;
      exit_to_reg     <= exit_to_next;
      power_state_o   <= pwr_next;
      // Decoding is off in power down and in the self refresh sub-state
      cmd_decode_en_o <= (pwr_next == `LPDB_PWR_NORM) | (pwr_next == `LPDB_PWR_SR);
      // Pulses when the exit ends after enough link clock rising edges
      exit_ready_o    <= (pwr_reg == `LPDB_PWR_EXIT) & (pwr_next != `LPDB_PWR_EXIT)
                         & (ck_cnt_next == `LPDB_CK_EDGES);
      // Data pins float or terminate only in idle power down
      dq_hiz_o        <= (pwr_next == `LPDB_PWR_IPD) & ~on_die_termination_i;
      dq_term_o       <= (pwr_next == `LPDB_PWR_IPD) & on_die_termination_i;
      illegal_cmd_o   <= (|bank_err) | sr_bad;
    end
  end

  // One state machine per bank
  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g = g + 1) begin : g_bank
      reg  [3:0] st_reg;   // Bank state
      reg  [3:0] ret_reg;  // State to return to after a mode access
      reg  [7:0] tmr_reg;  // Residence countdown
      reg  [7:0] bst_reg;  // Burst countdown
      wire       hit;      // Command names this bank
      wire       burst_on; // Data burst still running
      wire [3:0] code;

      assign code     = cmd_code_i;
      assign hit      = dec_en & cmd_valid_i & hits(code, cmd_bank_i, cmd_all_bank_i, g[2:0]);
      assign burst_on = (bst_reg != 8'h00);
      assign bank_idle[g] = (st_reg == `LPDB_BK_IDLE) & ~burst_on;

      // Flags a command that the bank's current state does not allow
      assign bank_err[g] = hit & (
        ((st_reg == `LPDB_BK_IDLE) & ((code == `LPDB_CMD_RD) | (code == `LPDB_CMD_WR))) |
        ((st_reg == `LPDB_BK_ACTG) & (code != `LPDB_CMD_MRR)) |
        ((st_reg == `LPDB_BK_PRE) & (code != `LPDB_CMD_MRR)) |
        (st_reg == `LPDB_BK_RDAP) | (st_reg == `LPDB_BK_WRAP) |
        ((st_reg == `LPDB_BK_RD) & (code == `LPDB_CMD_WR) & burst_on) |
        ((st_reg == `LPDB_BK_WR) & (code == `LPDB_CMD_RD) & burst_on) |
        (((st_reg == `LPDB_BK_RD) | (st_reg == `LPDB_BK_WR)) & (code != `LPDB_CMD_RD)
          & (code != `LPDB_CMD_WR) & (code != `LPDB_CMD_PRE)) |
        ((st_reg == `LPDB_BK_ACTV) & ((code == `LPDB_CMD_ACT) | (code == `LPDB_CMD_REFPB)
          | (code == `LPDB_CMD_REFAB)))) |
        // Refresh and mode access refuse any command at all
        (dec_en & cmd_valid_i & (st_reg >= `LPDB_BK_REFPB));

      // Bank transitions and residence timers
      always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          st_reg  <= `LPDB_BK_IDLE;
          ret_reg <= `LPDB_BK_IDLE;
          tmr_reg <= 8'h00;
          bst_reg <= 8'h00;
        end else begin
          if (burst_on)
            bst_reg <= bst_reg - 8'h01;
          if (tmr_reg != 8'h00)
            tmr_reg <= tmr_reg - 8'h01;
          case (st_reg)
            `LPDB_BK_IDLE: begin
              if (hit) begin
                case (code)
                  `LPDB_CMD_ACT: begin
                    st_reg  <= `LPDB_BK_ACTG;
                    tmr_reg <= RCD_CYC[7:0];
                  end
                  `LPDB_CMD_REFPB: begin
                    st_reg  <= `LPDB_BK_REFPB;
                    tmr_reg <= RFCPB_CYC[7:0];
                  end
                  `LPDB_CMD_REFAB: begin
                    // Honoured only once every bank is quiet
                    if (all_idle) begin
                      st_reg  <= `LPDB_BK_REFAB;
                      tmr_reg <= RFCAB_CYC[7:0];
                    end
                  end
                  `LPDB_CMD_MRW: begin
                    if (all_idle) begin
                      st_reg  <= `LPDB_BK_MRW;
                      ret_reg <= `LPDB_BK_IDLE;
                      tmr_reg <= MRW_CYC[7:0];
                    end
                  end
                  `LPDB_CMD_MRR: begin
                    st_reg  <= `LPDB_BK_MRR;
                    ret_reg <= `LPDB_BK_IDLE;
                    tmr_reg <= MRR_CYC[7:0];
                  end
                  `LPDB_CMD_PRE: begin
                    // Precharge of an idle bank still costs the full period
                    st_reg  <= `LPDB_BK_PRE;
                    tmr_reg <= RP_CYC[7:0];
                  end
                  default: st_reg <= `LPDB_BK_IDLE;
                endcase
              end
            end
            `LPDB_BK_ACTG: begin
              // Row becomes usable when the row-to-column delay is met
              if (tmr_reg == 8'h01)
                st_reg <= `LPDB_BK_ACTV;
            end
            `LPDB_BK_ACTV, `LPDB_BK_RD, `LPDB_BK_WR: begin
              if (hit && !bank_err[g]) begin
                case (code)
                  `LPDB_CMD_RD, `LPDB_CMD_WR: begin
                    bst_reg <= BURST_CYC[7:0];
                    if (auto_precharge_flag_i) begin
                      st_reg  <= (code == `LPDB_CMD_RD) ? `LPDB_BK_RDAP : `LPDB_BK_WRAP;
                      tmr_reg <= BURST_CYC[7:0] + RP_CYC[7:0];
                    end else begin
                      st_reg  <= (code == `LPDB_CMD_RD) ? `LPDB_BK_RD : `LPDB_BK_WR;
                    end
                  end
                  `LPDB_CMD_PRE: begin
                    st_reg  <= `LPDB_BK_PRE;
                    tmr_reg <= RP_CYC[7:0];
                  end
                  `LPDB_CMD_MRR: begin
                    st_reg  <= `LPDB_BK_MRR;
                    ret_reg <= `LPDB_BK_ACTV;
                    tmr_reg <= MRR_CYC[7:0];
                  end
                  `LPDB_CMD_MRW: begin
                    st_reg  <= `LPDB_BK_MRW;
                    ret_reg <= `LPDB_BK_ACTV;
                    tmr_reg <= MRW_CYC[7:0];
                  end
                  default: st_reg <= st_reg;
                endcase
              end
            end
            `LPDB_BK_RDAP, `LPDB_BK_WRAP, `LPDB_BK_PRE: begin
              // Closes to idle once the precharge period is met
              if (tmr_reg == 8'h01)
                st_reg <= `LPDB_BK_IDLE;
            end
            `LPDB_BK_REFPB, `LPDB_BK_REFAB: begin
              if (tmr_reg == 8'h01)
                st_reg <= `LPDB_BK_IDLE;
            end
            `LPDB_BK_MRR, `LPDB_BK_MRW: begin
              if (tmr_reg == 8'h01)
                st_reg <= ret_reg;
            end
            default: st_reg <= `LPDB_BK_IDLE;
          endcase
        end
      end

      // Bank state exported straight from a flop
      always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
          bank_state_o[g*4 +: 4] <= `LPDB_BK_IDLE;
        else
          bank_state_o[g*4 +: 4] <= st_reg;
      end
    end
  endgenerate

endmodule

// [lpdb_core_monitor.sv]
// Assertion checker for the DRAM power and bank sequencer ports
`timescale 1ns/100ps
`include "lpdb_regs.vh"
module lpdb_core_monitor #(
  parameter NUM_BANKS = 8,
  parameter XP_CYC    = 8,
  parameter XSR_CYC   = 32,
  parameter RCD_CYC   = 4
) (
  input wire                   sys_clk_i,
  input wire                   rst_n_i,
  input wire                   cke_i,
  input wire                   cmd_valid_i,
  input wire [3:0]             cmd_code_i,
  input wire [2:0]             cmd_bank_i,
  input wire                   on_die_termination_i,
  input wire [2:0]             power_state_o,
  input wire [NUM_BANKS*4-1:0] bank_state_o,
  input wire                   cmd_decode_en_o,
  input wire                   dq_hiz_o,
  input wire                   dq_term_o,
  input wire                   illegal_cmd_o
);
  localparam int EXIT_LIM = XP_CYC + XSR_CYC + 4; // Both exit periods added plus filter slack
  localparam int RCD_LIM  = RCD_CYC + 3;          // Activation plus output lag
  wire [3:0] bank0 = bank_state_o[3:0];           // Bank 0 is watched in detail
  wire [2:0] pwr   = power_state_o;               // Short alias
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Enable held low keeps active power down
  property p_apd_hold; (pwr == 3'h1 && !cke_i) [*5] |=> pwr == 3'h1; endproperty
  a_apd_hold: assert property (p_apd_hold) else $error("active power down left");
  // Filter delay of the enable bounds every power reaction
  property p_pd_exit; (pwr == 3'h1 || pwr == 3'h2) && $rose(cke_i) && !cmd_valid_i |-> ##[1:8] pwr == 3'h5;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("power down exit missed");
  property p_sr_down; pwr == 3'h3 && $fell(cke_i) |-> ##[1:8] (pwr == 3'h4 && !cmd_decode_en_o); endproperty
  a_sr_down: assert property (p_sr_down) else $error("self refresh power down missed");
  property p_sr_up; pwr == 3'h4 && $rose(cke_i) |-> ##[1:8] (pwr == 3'h3 && cmd_decode_en_o); endproperty
  a_sr_up: assert property (p_sr_up) else $error("self refresh decode not restored");
  // Bank occupancy picks the power down flavour
  property p_pd_enter; pwr == 3'h0 && $fell(cke_i) && !cmd_valid_i
    |-> ##[1:8] pwr == ((bank_state_o != 0) ? 3'h1 : 3'h2); endproperty
  a_pd_enter: assert property (p_pd_enter) else $error("wrong power down entered");
  property p_float; pwr == 3'h2 && $stable(on_die_termination_i)
    |-> dq_hiz_o == !on_die_termination_i && dq_term_o == on_die_termination_i; endproperty
  a_float: assert property (p_float) else $error("data pins wrong in idle power down");
  property p_act; $rose(bank0 == 4'h1) |-> ##[1:RCD_LIM] bank0 == 4'h2; endproperty
  a_act: assert property (p_act) else $error("activation did not complete");
  // Write landing inside a fresh read burst is refused
  property p_wr_in_rd; (cmd_valid_i && cmd_code_i == `LPDB_CMD_RD && cmd_bank_i == 3'h0 && bank0 == 4'h2)
    ##1 (cmd_valid_i && cmd_code_i == `LPDB_CMD_WR && cmd_bank_i == 3'h0) |=> ##[0:1] illegal_cmd_o; endproperty
  a_wr_in_rd: assert property (p_wr_in_rd) else $error("write in read burst not flagged");
  property p_sr_cmd; pwr == 3'h3 && cmd_valid_i && cmd_code_i inside {[4'h1:4'h6]} |-> ##[1:2] illegal_cmd_o;
  endproperty
  a_sr_cmd: assert property (p_sr_cmd) else $error("bank command in self refresh not flagged");
  property p_exit_end; $rose(pwr == 3'h5) |-> ##[1:EXIT_LIM] pwr == 3'h0; endproperty
  a_exit_end: assert property (p_exit_end) else $error("exit wait did not end");
endmodule
bind lpdb_core lpdb_core_monitor #(.NUM_BANKS(NUM_BANKS), .XP_CYC(XP_CYC), .XSR_CYC(XSR_CYC), .RCD_CYC(RCD_CYC))
  i_mon (.sys_clk_i, .rst_n_i, .cke_i, .cmd_valid_i, .cmd_code_i, .cmd_bank_i, .on_die_termination_i,
  .power_state_o, .bank_state_o, .cmd_decode_en_o, .dq_hiz_o, .dq_term_o, .illegal_cmd_o);

// [lpdb_ctl_model.sv]
// Memory controller model: clock enable, link clock and decoded commands
`timescale 1ns/100ps
`include "lpdb_regs.vh"
module lpdb_ctl_model (
  input  wire       sys_clk_i,
  input  wire [2:0] power_state_i,
  input  wire       illegal_cmd_i,
  input  wire       exit_ready_i,
  output reg        cke_o,
  output reg        ck_o,
  output reg        cmd_valid_o,
  output reg  [3:0] cmd_code_o,
  output reg  [2:0] cmd_bank_o,
  output reg        ap_o
);
  reg ck_run; // Link clock only runs around exits
  // Idle levels at time zero
  initial begin
    cke_o = 1'b1;
    ck_o = 1'b0;
    ck_run = 1'b0;
    cmd_valid_o = 1'b0;
    cmd_code_o = 4'h0;
    cmd_bank_o = 3'h0;
    ap_o = 1'b0;
  end
  // Offset keeps link edges off the command clock grid
  initial begin
    #13;
    forever begin
      #400;
      if (ck_run) ck_o = ~ck_o;
    end
  end
  // One command pulse; the refusal flag is gathered over two cycles
  task cmd(input [3:0] c, input [2:0] b, input ap, output reg ill);
    begin
      cmd_code_o = c;
      cmd_bank_o = b;
      ap_o = ap;
      cmd_valid_o = 1'b1;
      @(negedge sys_clk_i);
      cmd_valid_o = 1'b0;
      ill = illegal_cmd_i;
      @(negedge sys_clk_i);
      ill = ill | illegal_cmd_i;
    end
  endtask
  // Two commands back to back; flag covers the second
  task b2b(input [3:0] c1, input [3:0] c2, input [2:0] b, output reg ill);
    begin
      cmd_code_o = c1;
      cmd_bank_o = b;
      ap_o = 1'b0;
      cmd_valid_o = 1'b1;
      @(negedge sys_clk_i);
      cmd(c2, b, 1'b0, ill);
    end
  endtask
  // Enable moves off the clock grid under deselect, then settles
  task set_cke(input v);
    begin
      cmd_valid_o = 1'b0;
      #37;
      cke_o = v;
      repeat (8) @(negedge sys_clk_i);
    end
  endtask
  // Exit with the link clock running; deselect only until normal again
  task exit_pd(input srx, output reg saw5, output reg rdy);
    integer n;
    reg     ill;
    begin
      saw5 = 1'b0;
      rdy = 1'b0;
      ck_run = 1'b1;
      repeat (8) @(negedge sys_clk_i);
      if (srx) cmd(`LPDB_CMD_SRX, 3'h0, 1'b0, ill);
      else set_cke(1'b1);
      for (n = 0; n < 200 && power_state_i !== 3'h0; n = n + 1) begin
        if (power_state_i === 3'h5) saw5 = 1'b1;
        if (exit_ready_i === 1'b1) rdy = 1'b1;
        @(negedge sys_clk_i);
      end
      rdy = rdy | exit_ready_i;
      ck_run = 1'b0;
    end
  endtask
endmodule

// [lpdb_tb.sv]
// Self-checking bench for the DRAM power and bank sequencer
`timescale 1ns/100ps
`include "lpdb_regs.vh"
`define CHK(nm, e, g) begin \
  tests_run = tests_run + 1; \
  if ((g) !== (e)) begin \
    bad_count = bad_count + 1; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, (e), (g)); \
  end \
end
module tb;
  localparam RP = `LPDB_RP_CYC; // Design defaults
  localparam BURST = `LPDB_BURST_CYC;
  localparam RFCPB = `LPDB_RFCPB_CYC;
  localparam RFCAB = `LPDB_RFCAB_CYC;
  localparam MRR = `LPDB_MRR_CYC;
  localparam MRW = `LPDB_MRW_CYC;
  reg         sys_clk;
  reg         rst_n;
  reg         on_die_termination;
  wire        cke, ck, cmd_valid, ap, dec_en, exit_rdy, dq_hiz, dq_term, illegal;
  wire [3:0]  code;
  wire [2:0]  bank;
  wire [2:0]  pwr;
  wire [31:0] bst;
  integer     bad_count;
  integer     tests_run;
  integer     o;
  reg         ill, saw5, rdy, allb;
  lpdb_core #(.XP_CYC(24)) i_lpdb_core (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
    .cke_i(cke), .ck_i(ck), .cmd_valid_i(cmd_valid), .cmd_code_i(code), .cmd_bank_i(bank),
    .cmd_all_bank_i(allb), .auto_precharge_flag_i(ap), .on_die_termination_i(on_die_termination), .power_state_o(pwr),
    .bank_state_o(bst), .cmd_decode_en_o(dec_en), .exit_ready_o(exit_rdy), .dq_hiz_o(dq_hiz),
    .dq_term_o(dq_term), .illegal_cmd_o(illegal));
  lpdb_ctl_model i_ctl (.sys_clk_i(sys_clk), .power_state_i(pwr), .illegal_cmd_i(illegal),
    .exit_ready_i(exit_rdy), .cke_o(cke), .ck_o(ck), .cmd_valid_o(cmd_valid), .cmd_code_o(code),
    .cmd_bank_o(bank), .ap_o(ap));
  // Command clock, 100 ns period
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Verdict and end of run
  task tally_and_finish;
    begin
      if (bad_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  // Bounded wait for a bank field value
  task wb(input integer b, input [3:0] v, input integer lim);
    integer n;
    begin
      for (n = 0; n < lim && bst[4*b +: 4] !== v; n = n + 1) @(negedge sys_clk);
    end
  endtask
  // Burst conflicts and auto precharge on bank 0
  task t_bank;
    begin
      i_ctl.cmd(`LPDB_CMD_ACT, 3'h0, 1'b0, ill);
      `CHK("activating", 4'h1, bst[3:0])
      wb(0, 4'h2, 10);
      i_ctl.b2b(`LPDB_CMD_RD, `LPDB_CMD_WR, 3'h0, ill);
      `CHK("wr in rd burst", 1'b1, ill)
      `CHK("reading", 4'h3, bst[3:0])
      repeat (BURST + 2) @(negedge sys_clk);
      i_ctl.b2b(`LPDB_CMD_WR, `LPDB_CMD_RD, 3'h0, ill);
      `CHK("rd in wr burst", 1'b1, ill)
      `CHK("writing", 4'h4, bst[3:0])
      repeat (BURST + 2) @(negedge sys_clk);
      i_ctl.cmd(`LPDB_CMD_RD, 3'h0, 1'b1, ill);
      `CHK("rd ap", 4'h5, bst[3:0])
      i_ctl.cmd(`LPDB_CMD_ACT, 3'h0, 1'b0, ill);
      `CHK("act in rd ap", 1'b1, ill)
      wb(0, 4'h0, BURST + RP + 4);
      `CHK("rd ap idle", 4'h0, bst[3:0])
    end
  endtask
  // Refreshes and mode register accesses
  task t_ref;
    begin
      i_ctl.cmd(`LPDB_CMD_REFPB, 3'h1, 1'b0, ill);
      `CHK("bank refresh", 4'h8, bst[7:4])
      i_ctl.cmd(`LPDB_CMD_ACT, 3'h1, 1'b0, ill);
      `CHK("act in refresh", 1'b1, ill)
      wb(1, 4'h0, RFCPB + 4);
      `CHK("bank refresh end", 4'h0, bst[7:4])
      i_ctl.cmd(`LPDB_CMD_REFAB, 3'h0, 1'b0, ill);
      `CHK("all refresh", {8{4'h9}}, bst)
      wb(7, 4'h0, RFCAB + 4);
      `CHK("all refresh end", 32'h0, bst)
      i_ctl.cmd(`LPDB_CMD_MRW, 3'h0, 1'b0, ill);
      `CHK("mr writing", 4'hb, bst[3:0])
      wb(0, 4'h0, MRW + 4);
      `CHK("mr write idle", 4'h0, bst[3:0])
      i_ctl.cmd(`LPDB_CMD_ACT, 3'h0, 1'b0, ill);
      wb(0, 4'h2, 10);
      i_ctl.cmd(`LPDB_CMD_MRR, 3'h0, 1'b0, ill);
      `CHK("mr reading", 4'ha, bst[3:0])
      wb(0, 4'h2, MRR + 4);
      `CHK("mr read active", 4'h2, bst[3:0])
    end
  endtask
  // Active power down with bank 0 open, then precharge
  task t_apd;
    begin
      i_ctl.set_cke(1'b0);
      `CHK("active pd", 3'h1, pwr)
      i_ctl.cmd(`LPDB_CMD_PRE, 3'h0, 1'b0, ill);
      repeat (6) @(negedge sys_clk);
      `CHK("active pd kept", 3'h1, pwr)
      i_ctl.exit_pd(1'b0, saw5, rdy);
      `CHK("apd exit wait", 1'b1, saw5)
      `CHK("bank kept", 4'h2, bst[3:0])
      allb = 1'b1;
      i_ctl.cmd(`LPDB_CMD_PRE, 3'h0, 1'b0, ill);
      `CHK("precharging", 4'h7, bst[3:0])
      `CHK("precharge all", 4'h7, bst[7:4])
      wb(0, 4'h0, RP + 4);
      `CHK("precharge idle", 4'h0, bst[3:0])
    end
  endtask
  // Idle power down with termination off and on
  task t_ipd;
    begin
      for (o = 0; o < 2; o = o + 1) begin
        on_die_termination = o[0];
        i_ctl.set_cke(1'b0);
        `CHK("idle pd", 3'h2, pwr)
        `CHK("dq float", !o[0], dq_hiz)
        `CHK("dq term", o[0], dq_term)
        i_ctl.cmd(`LPDB_CMD_ACT, 3'h0, 1'b0, ill);
        `CHK("cmd ignored", 4'h0, bst[3:0])
        i_ctl.exit_pd(1'b0, saw5, rdy);
        `CHK("ipd exit wait", 1'b1, saw5)
        `CHK("ipd exit ready", 1'b1, rdy)
        `CHK("ipd idle", 3'h0, pwr)
      end
    end
  endtask
  // Self refresh, its power-down sub-state and exit
  task t_self_refresh_state;
    begin
      i_ctl.cmd(`LPDB_CMD_SRE, 3'h0, 1'b0, ill);
      i_ctl.cmd(`LPDB_CMD_ACT, 3'h0, 1'b0, ill);
      `CHK("act in sr", 1'b1, ill)
      i_ctl.cmd(`LPDB_CMD_MRR, 3'h0, 1'b0, ill);
      `CHK("mrr in sr", 1'b0, ill)
      wb(0, 4'h0, MRR + 4);
      i_ctl.set_cke(1'b0);
      `CHK("sr pd", 3'h4, pwr)
      `CHK("decode off", 1'b0, dec_en)
      i_ctl.set_cke(1'b1);
      `CHK("sr back", 3'h3, pwr)
      `CHK("decode on", 1'b1, dec_en)
      i_ctl.exit_pd(1'b1, saw5, rdy);
      `CHK("sr exit wait", 1'b1, saw5)
      `CHK("sr exit ready", 1'b1, rdy)
    end
  endtask
  // Reset, then every scenario in turn
  initial begin
    rst_n = 1'b0;
    on_die_termination = 1'b0;
    allb = 1'b0;
    bad_count = 0;
    tests_run = 0;
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    t_bank;
    t_ref;
    t_apd;
    t_ipd;
    t_self_refresh_state;
    tally_and_finish;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #2000000;
    bad_count = bad_count + 1;
    tally_and_finish;
  end
endmodule
